// *** rtl/eidr_params.svh ***
`ifndef EIDR_PARAMS_SVH
`define EIDR_PARAMS_SVH

// Register byte offsets
`define EIDR_ADDR_TYPE     8'h00
`define EIDR_ADDR_ENABLE   8'h04
`define EIDR_ADDR_PRIO     8'h08
`define EIDR_ADDR_FLAGS    8'h0C
`define EIDR_ADDR_STATUS   8'h10

// Field positions
`define EIDR_GLOBAL_EN_BIT 8
`define EIDR_ST_INSVC_HI   0
`define EIDR_ST_INSVC_LO   1
`define EIDR_ST_CALL       2
`define EIDR_ST_SRC_LSB    4

// Poll order, also the source index
`define EIDR_SRC_EXT0      0
`define EIDR_SRC_TMR0      1
`define EIDR_SRC_EXT1      2
`define EIDR_SRC_TMR1      3
`define EIDR_SRC_SERIAL    4
`define EIDR_SRC_TMR2      5
`define EIDR_SRC_EXT2      6
`define EIDR_SRC_EXT3      7

// Reset values
`define EIDR_RST_TYPE      4'h0
`define EIDR_RST_ENABLE    9'h000
`define EIDR_RST_PRIO      8'h00
`define EIDR_RST_PIN       4'hF

// Timing, in system clocks
`define EIDR_CALL_CYCLES   6
`define EIDR_MIN_RESPONSE  7
`define EIDR_MACHINE_CLKS  12

// Vector is {source, low bits}
`define EIDR_VEC_LOW       3'h3

`endif

// *** rtl/eidr_pkg.sv ***
package eidr_pkg;

  // Status of the instruction sequencer, sampled each clock
  typedef struct packed {
    logic lastCycle;
    logic blockInstr;
    logic flashBusy;
    logic retiDone;
  } eidr_core_s;

  // Hardware call towards the core
  typedef struct packed {
    logic        active;
    logic        firstInstr;
    logic [2:0]  source;
    logic [15:0] vector;
  } eidr_call_s;

  typedef enum logic [0:0] {
    EIDR_IDLE,
    EIDR_CALL
  } eidr_state_e;

endpackage

// *** rtl/eidr_ctrl.sv ***
// What this block does
// - Four external inputs; type 0 means low-level request
// - Type 1 sets flag on high-then-low samples
// - Edge flag cleared by the hardware call
// - Level still active at return requests again
// - Pins inverted and latched every clock
// - Timer overflow sets flag, polled next clock
// - Unblocked request makes six-clock hardware call next
// - Seven clocks minimum from request to routine
// - Equal or higher level in service holds off
// - Waits for current instruction's final cycle
// - Return or enable/priority access delays one instruction
// - Single source response seven to twelve cycles
// - Software-set timer flag requests if enabled
// - Timer 0 before timer 1 at same level
// - Fixed vector address per source
// - Fixed polling order within a priority level
// - No call during flash self programming
// - Extra sources have enable, priority; flag is the raw request, no type
`timescale 1ns/1ps

`include "eidr_params.svh"

module eidr_ctrl
  import eidr_pkg::*;
#(
  parameter int CALL_CYCLES = `EIDR_CALL_CYCLES
)
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // External request pins, active low
  input  wire logic [3:0]  extPinN,
  // Peripheral requests
  input  wire logic [1:0]  timerOvf,
  input  wire logic        serialReq,
  input  wire logic        timer2Req,
  // Core side
  input  wire eidr_core_s  coreIn,
  output eidr_call_s       callOut
);

  if (CALL_CYCLES < 1 || CALL_CYCLES > 7)
  begin : g_chk
    $error("CALL_CYCLES must lie in 1..7");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [3:0]  extTypeSel_r;
  logic [8:0]  enable_r;
  logic [7:0]  prio_r;
  logic [3:0]  pinPrev_r;
  logic [3:0]  extFlag_r;
  logic [1:0]  tmrFlag_r;
  logic        inSvcHi_r;
  logic        inSvcLo_r;
  eidr_state_e state_r;
  logic [2:0]  callCnt_r;
  logic [2:0]  callSrc_r;
  logic [15:0] callVec_r;
  logic        firstInstr_r;
  logic [31:0] prdata_r;
  logic        slvErr_r;

  logic [7:0]  srcFlags;
  logic [7:0]  pending;
  logic [7:0]  hiReq;
  logic [7:0]  loReq;
  logic [7:0]  levelReq;
  logic        canTake;
  logic        selHi;
  logic [2:0]  selSrc;
  logic        blocked;
  logic        take;
  logic        addrHit;
  logic [31:0] rdMux;
  logic        wrEn;
  logic        lastCall;

  //////////////////////////////////////////////////////////////////////////////
  // APB slave: read data and error are captured in the setup cycle
  always_comb
  begin
    addrHit = 1'b1;
    rdMux   = 32'h0000_0000;
    case (paddr)
      `EIDR_ADDR_TYPE:   rdMux[3:0] = extTypeSel_r;
      `EIDR_ADDR_ENABLE: rdMux[8:0] = enable_r;
      `EIDR_ADDR_PRIO:   rdMux[7:0] = prio_r;
      `EIDR_ADDR_FLAGS:  rdMux[7:0] = srcFlags;
      `EIDR_ADDR_STATUS:
      begin
        rdMux[`EIDR_ST_INSVC_HI]                       = inSvcHi_r;
        rdMux[`EIDR_ST_INSVC_LO]                       = inSvcLo_r;
        rdMux[`EIDR_ST_CALL]                           = (state_r == EIDR_CALL);
        rdMux[`EIDR_ST_SRC_LSB+2:`EIDR_ST_SRC_LSB]     = callSrc_r;
      end
      default:           addrHit = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      prdata_r <= 32'h0000_0000;
      slvErr_r <= 1'b0;
    end
    else if (psel && !penable)
    begin
      prdata_r <= pwrite ? 32'h0000_0000 : rdMux;
      slvErr_r <= !addrHit;
    end
  end

  assign pready  = psel & penable;
  assign pslverr = psel & penable & slvErr_r;
  assign prdata  = prdata_r;
  assign wrEn    = psel & penable & pwrite & !slvErr_r;

  // Type bits for the four external inputs, enable and priority bits for all sources
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      extTypeSel_r <= `EIDR_RST_TYPE;
      enable_r     <= `EIDR_RST_ENABLE;
      prio_r       <= `EIDR_RST_PRIO;
    end
    else if (wrEn)
    begin
      case (paddr)
        `EIDR_ADDR_TYPE:   extTypeSel_r <= pwdata[3:0];
        `EIDR_ADDR_ENABLE: enable_r     <= pwdata[8:0];
        `EIDR_ADDR_PRIO:   prio_r       <= pwdata[7:0];
        default:           ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // External request flags
  // Idle-high reset value; types reset to level, so a pin low out of reset is taken as a level request
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      pinPrev_r <= `EIDR_RST_PIN;
    else
      pinPrev_r <= extPinN;
  end

  for (genvar i = 0; i < 4; i++)
  begin : g_ext
    localparam int SRC = (i == 0) ? `EIDR_SRC_EXT0 :
                         (i == 1) ? `EIDR_SRC_EXT1 :
                         (i == 2) ? `EIDR_SRC_EXT2 : `EIDR_SRC_EXT3;
    logic clrExt;
    assign clrExt = take && (selSrc == 3'(SRC));
    always_ff @(posedge mclk or posedge sys_rst)
    begin
      if (sys_rst)
        extFlag_r[i] <= 1'b0;
      else if (!extTypeSel_r[i])
        extFlag_r[i] <= ~extPinN[i];
      else
        extFlag_r[i] <= (pinPrev_r[i] & ~extPinN[i]) |
                        (extFlag_r[i] & ~clrExt);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Timer overflow flags: overflow beats software write and call clear
  for (genvar j = 0; j < 2; j++)
  begin : g_tmr
    localparam int SRC = (j == 0) ? `EIDR_SRC_TMR0 : `EIDR_SRC_TMR1;
    logic swWr;
    logic clrTmr;
    assign swWr   = wrEn && (paddr == `EIDR_ADDR_FLAGS);
    assign clrTmr = take && (selSrc == 3'(SRC));
    always_ff @(posedge mclk or posedge sys_rst)
    begin
      if (sys_rst)
        tmrFlag_r[j] <= 1'b0;
      else if (timerOvf[j])
        tmrFlag_r[j] <= 1'b1;
      else if (swWr)
        tmrFlag_r[j] <= pwdata[SRC];
      else if (clrTmr)
        tmrFlag_r[j] <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Polling: current flags only, nothing is held across a block
  assign srcFlags = {extFlag_r[3], extFlag_r[2], timer2Req, serialReq,
                     tmrFlag_r[1], extFlag_r[1], tmrFlag_r[0], extFlag_r[0]};
  assign pending  = srcFlags & enable_r[7:0] & {8{enable_r[`EIDR_GLOBAL_EN_BIT]}};
  assign hiReq    = pending & prio_r;
  assign loReq    = pending & ~prio_r;

  function automatic logic [2:0] first_set(input logic [7:0] m);
    logic [2:0] idx;
    idx = 3'h0;
    for (int k = 7; k >= 0; k--)
      if (m[k])
        idx = 3'(k);
    return idx;
  endfunction

  always_comb
  begin
    selHi    = 1'b0;
    canTake  = 1'b0;
    levelReq = 8'h00;
    if ((hiReq != 8'h00) && !inSvcHi_r)
    begin
      selHi    = 1'b1;
      canTake  = 1'b1;
      levelReq = hiReq;
    end
    else if ((loReq != 8'h00) && !inSvcHi_r && !inSvcLo_r)
    begin
      canTake  = 1'b1;
      levelReq = loReq;
    end
  end

  assign selSrc  = first_set(levelReq);
  // Return and enable/priority accesses raise blockInstr for one instruction
  assign blocked = !coreIn.lastCycle || coreIn.blockInstr ||
                   coreIn.flashBusy || (state_r == EIDR_CALL);
  assign take    = canTake && !blocked;

  //////////////////////////////////////////////////////////////////////////////
  // In-service levels; a return pops the highest one
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      inSvcHi_r <= 1'b0;
      inSvcLo_r <= 1'b0;
    end
    else
    begin
      inSvcHi_r <= (inSvcHi_r & ~coreIn.retiDone) | (take & selHi);
      inSvcLo_r <= (inSvcLo_r & ~(coreIn.retiDone & ~inSvcHi_r)) | (take & ~selHi);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Hardware call sequence
  assign lastCall = (callCnt_r == 3'(CALL_CYCLES - 1));

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_r   <= EIDR_IDLE;
      callCnt_r <= 3'h0;
    end
    else
    begin
      case (state_r)
        EIDR_IDLE:
          if (take)
          begin
            state_r   <= EIDR_CALL;
            callCnt_r <= 3'h0;
          end
        EIDR_CALL:
          if (lastCall)
            state_r <= EIDR_IDLE;
          else
            callCnt_r <= callCnt_r + 3'h1;
        default:
          state_r <= EIDR_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      callSrc_r <= 3'h0;
      callVec_r <= 16'h0000;
    end
    else if (take)
    begin
      callSrc_r <= selSrc;
      callVec_r <= {10'h000, selSrc, `EIDR_VEC_LOW};
    end
  end

  // Marks the first routine instruction, in the first clock after the call's last clock
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      firstInstr_r <= 1'b0;
    else
      firstInstr_r <= (state_r == EIDR_CALL) && lastCall;
  end

  assign callOut.active     = (state_r == EIDR_CALL);
  assign callOut.firstInstr = firstInstr_r;
  assign callOut.source     = callSrc_r;
  assign callOut.vector     = callVec_r;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  sequence s_call_body;
    callOut.active [*6];
  endsequence
  sequence s_call_done;
    !callOut.active ##0 callOut.firstInstr;
  endsequence

  a_call_length: assert property (take && CALL_CYCLES == 6 |=> s_call_body ##1 s_call_done)
    else $error("hardware call did not last six clocks");
  a_min_response: assert property (callOut.firstInstr |->
      $past(take, 7) && !$past(callOut.active, 7))
    else $error("routine started less than seven clocks after the poll");
  a_edge_clear: assert property (take && selSrc == 3'h0 && extTypeSel_r[0] &&
      !(pinPrev_r[0] && !extPinN[0]) |=> !extFlag_r[0])
    else $error("edge flag not cleared by the call");
  a_edge_set: assert property (extTypeSel_r[0] && pinPrev_r[0] && !extPinN[0]
      |=> extFlag_r[0])
    else $error("falling edge did not set flag");
  a_level_follow: assert property (!extTypeSel_r[1] |=>
      extFlag_r[1] == !$past(extPinN[1]))
    else $error("level flag does not follow inverted pin");
  a_block_conds: assert property (take |->
      coreIn.lastCycle && !coreIn.blockInstr && !coreIn.flashBusy)
    else $error("call taken while blocked");
  a_prio_hold: assert property (take |-> !inSvcHi_r && (selHi || !inSvcLo_r))
    else $error("call taken over equal or higher level in service");
  a_enable_gate: assert property (take |-> enable_r[selSrc] &&
      enable_r[`EIDR_GLOBAL_EN_BIT])
    else $error("disabled source taken");
  a_poll_order: assert property (take && levelReq[`EIDR_SRC_TMR0] |-> selSrc <= 3'h1)
    else $error("timer 1 or later source taken before timer 0");
  a_vector_map: assert property (callOut.active |->
      callOut.vector == {10'h000, callOut.source, 3'h3})
    else $error("vector does not match source");

endmodule

// *** tb/eidr_src_model.sv ***
`timescale 1ns/1ps

module eidr_src_model (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  // Bench request, 1 pulls the pin low
  input  wire logic [3:0] reqLow,
  // Pins towards the block
  output logic      [3:0] extPinN
);
  logic [3:0] age_r [4];

  ////////////////////////////////////////////////////////////////
  // A level stands 12 clocks before it may change
  // Level requests stay low until the bench lets go
  // Released pins read high, as through a pull-up
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      extPinN <= 4'hF;
      for (int i = 0; i < 4; i++)
        age_r[i] <= 4'h0;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (age_r[i] < 4'hB)
          age_r[i] <= age_r[i] + 4'h1;
        else if (extPinN[i] == reqLow[i])
        begin
          extPinN[i] <= ~reqLow[i];
          age_r[i]   <= 4'h0;
        end
      end
    end
  end
endmodule

// *** tb/tb_external_interrupt_detect_response.sv ***
`timescale 1ns/1ps

`include "eidr_params.svh"

module tb_external_interrupt_detect_response
  import eidr_pkg::*;
;
  typedef struct packed {
    logic [1:0]  pin;
    logic        edgeMode;
    logic [2:0]  src;
    logic [15:0] vec;
  } eidr_row_s;

  logic        mclk, sys_rst, psel, penable, pwrite, pready, pslverr, serialReq, timer2Req, rerr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [3:0]  extPinN, reqLow;
  logic [1:0]  timerOvf;
  eidr_core_s  coreIn;
  eidr_call_s  callOut;
  eidr_row_s   rows [8];
  int          failures, totalChecks, n;

  eidr_ctrl eidr_ctrl_inst (.mclk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .extPinN, .timerOvf, .serialReq, .timer2Req, .coreIn, .callOut);
  eidr_src_model eidr_src_model_inst (.mclk, .sys_rst, .reqLow, .extPinN);

  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////
  task automatic final_report();
    if (failures == 0 && totalChecks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic hang();
    failures++;
    final_report();
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge mclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge mclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k >= 20)
      hang();
  endtask

  task automatic req(input int i, input logic v);
    @(posedge mclk);
    reqLow[i] <= v;
  endtask

  task automatic pin_is(input int i, input logic v);
    int k;
    k = 0;
    do
    begin
      @(negedge mclk);
      k++;
    end
    while (extPinN[i] !== v && k < 40);
    if (k >= 40)
      hang();
  endtask

  // Counts clocks to the first routine instruction, checks the call
  task automatic call_seen(input logic [2:0] src, input logic [15:0] vec);
    int act;
    act = 0;
    n = 0;
    while (callOut.firstInstr !== 1'b1 && n < 60)
    begin
      @(negedge mclk);
      n++;
      if (callOut.active === 1'b1)
        act++;
    end
    if (n >= 60)
      hang();
    chk("call length", act, `EIDR_CALL_CYCLES);
    chk("source", {29'h0, callOut.source}, {29'h0, src});
    chk("vector", {16'h0, callOut.vector}, {16'h0, vec});
  endtask

  task automatic no_call(input int c);
    int hits;
    hits = 0;
    repeat (c)
    begin
      @(negedge mclk);
      if (callOut.active !== 1'b0)
        hits++;
    end
    chk("no call", hits, 0);
  endtask

  task automatic return_from_interrupt();
    @(posedge mclk);
    coreIn.retiDone <= 1'b1;
    @(posedge mclk);
    coreIn.retiDone <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////
  initial
  begin
    rows = '{'{2'h0, 1'h1, 3'h0, 16'h0003}, '{2'h1, 1'h1, 3'h2, 16'h0013}, '{2'h2, 1'h1, 3'h6, 16'h0033},
             '{2'h3, 1'h1, 3'h7, 16'h003B}, '{2'h0, 1'h0, 3'h0, 16'h0003}, '{2'h1, 1'h0, 3'h2, 16'h0013},
             '{2'h2, 1'h0, 3'h6, 16'h0033}, '{2'h3, 1'h0, 3'h7, 16'h003B}};
    {sys_rst, psel, penable, pwrite, serialReq, timer2Req} = 6'h20;
    {paddr, pwdata, reqLow, timerOvf} = '0;
    coreIn = '{lastCycle: 1'b1, blockInstr: 1'b0, flashBusy: 1'b0, retiDone: 1'b0};
    failures = 0;
    totalChecks = 0;
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    for (int a = 0; a <= 16; a += 4)
    begin
      apb(1'b0, 8'(a), 32'h0);
      chk("reset value", rdata, 32'h0);
    end
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped error", {31'h0, rerr}, 32'h1);
    // Each external pin in both modes
    foreach (rows[r])
    begin
      apb(1'b1, `EIDR_ADDR_TYPE, 32'(rows[r].edgeMode) << rows[r].pin);
      apb(1'b1, `EIDR_ADDR_ENABLE, 32'h100 | (32'h1 << rows[r].src));
      req(rows[r].pin, 1'b1);
      pin_is(rows[r].pin, 1'b0);
      call_seen(rows[r].src, rows[r].vec);
      chk("latency", n, `EIDR_CALL_CYCLES + 2);
      apb(1'b0, `EIDR_ADDR_FLAGS, 32'h0);
      chk("flag after call", rdata, 32'(!rows[r].edgeMode) << rows[r].src);
      req(rows[r].pin, 1'b0);
      pin_is(rows[r].pin, 1'b0 + 1'b1);
      return_from_interrupt();
    end
    // Level still low at return calls again
    apb(1'b1, `EIDR_ADDR_TYPE, 32'h0);
    apb(1'b1, `EIDR_ADDR_ENABLE, 32'h104);
    req(1, 1'b1);
    call_seen(3'h2, 16'h0013);
    return_from_interrupt();
    call_seen(3'h2, 16'h0013);
    req(1, 1'b0);
    pin_is(1, 1'b1);
    return_from_interrupt();
    // Flash programming blocks; a vanished request is forgotten
    apb(1'b1, `EIDR_ADDR_ENABLE, 32'h101);
    coreIn.flashBusy <= 1'b1;
    req(0, 1'b1);
    no_call(30);
    req(0, 1'b0);
    pin_is(0, 1'b1);
    @(posedge mclk);
    coreIn.flashBusy <= 1'b0;
    no_call(20);
    req(0, 1'b1);
    coreIn.blockInstr <= 1'b1;
    no_call(30);
    @(posedge mclk);
    coreIn.blockInstr <= 1'b0;
    call_seen(3'h0, 16'h0003);
    chk("after block", n, `EIDR_CALL_CYCLES + 2);
    req(0, 1'b0);
    pin_is(0, 1'b1);
    return_from_interrupt();
    // Timer flags: software set, overflow set, enable gating, order
    apb(1'b1, `EIDR_ADDR_ENABLE, 32'h100);
    apb(1'b1, `EIDR_ADDR_FLAGS, 32'h2);
    @(posedge mclk);
    timerOvf[1] <= 1'b1;
    @(posedge mclk);
    timerOvf[1] <= 1'b0;
    no_call(10);
    apb(1'b0, `EIDR_ADDR_FLAGS, 32'h0);
    chk("timer flags", rdata, 32'hA);
    apb(1'b1, `EIDR_ADDR_ENABLE, 32'h10A);
    call_seen(3'h1, 16'h000B);
    apb(1'b0, `EIDR_ADDR_FLAGS, 32'h0);
    chk("timer0 cleared", rdata, 32'h8);
    return_from_interrupt();
    call_seen(3'h3, 16'h001B);
    return_from_interrupt();
    // Low level in service: low held off, high preempts
    apb(1'b1, `EIDR_ADDR_PRIO, 32'h4);
    apb(1'b1, `EIDR_ADDR_ENABLE, 32'h145);
    req(0, 1'b1);
    call_seen(3'h0, 16'h0003);
    req(0, 1'b0);
    req(2, 1'b1);
    no_call(30);
    req(1, 1'b1);
    call_seen(3'h2, 16'h0013);
    apb(1'b0, `EIDR_ADDR_STATUS, 32'h0);
    chk("nested service", rdata, 32'h23);
    req(1, 1'b0);
    req(2, 1'b0);
    pin_is(2, 1'b1);
    pin_is(1, 1'b1);
    return_from_interrupt();
    return_from_interrupt();
    // Serial before timer 2; a poll mid-instruction is held off
    coreIn.lastCycle <= 1'b0;
    serialReq        <= 1'b1;
    timer2Req        <= 1'b1;
    apb(1'b1, `EIDR_ADDR_ENABLE, 32'h130);
    no_call(10);
    @(posedge mclk);
    coreIn.lastCycle <= 1'b1;
    call_seen(3'h4, 16'h0023);
    @(posedge mclk);
    serialReq <= 1'b0;
    return_from_interrupt();
    call_seen(3'h5, 16'h002B);
    @(posedge mclk);
    timer2Req <= 1'b0;
    return_from_interrupt();
    apb(1'b0, `EIDR_ADDR_STATUS, 32'h0);
    chk("status idle", rdata, 32'h50);
    // Mid-run reset returns registers and call outputs to idle
    apb(1'b1, `EIDR_ADDR_TYPE, 32'hF);
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    chk("call after reset", {11'h000, callOut}, 32'h0);
    apb(1'b0, `EIDR_ADDR_TYPE, 32'h0);
    chk("type after reset", rdata, 32'h0);
    apb(1'b0, `EIDR_ADDR_STATUS, 32'h0);
    chk("status after reset", rdata, 32'h0);
    final_report();
  end
endmodule
